// ### hw/obcd_option_decode.sv
// option byte store, reset-phase sequencer and static configuration decode
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`include "obcd_map.svh"

module obcd_option_decode (
  input  wire logic             CLK,
  input  wire logic             RST_B,
  input  wire logic [3:0]       WB_ADR_I,
  input  wire logic [7:0]       WB_DAT_I,
  input  wire logic             WB_WE_I,
  input  wire logic             WB_SEL_I,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  output logic      [7:0]       WB_DAT_O,
  output logic                  WB_ACK_O,
  input  wire logic             PROG_MODE_PIN,
  input  wire logic             TEST_MODE_PIN,
  input  wire logic             HALT_ENTRY,
  input  wire logic             HALT_EXIT,
  input  wire logic             WDG_RUNNING,
  input  wire logic             MEM_ERASE_DONE,
  output logic                  MEM_ERASE_REQ,
  output logic                  CPU_RESET_HOLD,
  output logic                  HALT_WDG_RESET,
  output logic                  WDG_HW_ENABLE,
  output logic                  CLK_SEL_PLL,
  output logic                  LOW_SUPPLY_DETECTOR_EN,
  output logic                  AUX_SUPPLY_DETECTOR_EN,
  output logic                  INPUT_CLOCK_HALVER_EN,
  output logic                  USER_MEM_ACCESS_BLOCK,
  output obcd_pkg::obcd_byte_t  ACTIVE_OPTIONS
);
  import obcd_pkg::*;

  obcd_byte_t  store;
  obcd_byte_t  active;
  obcd_phase_t phase;
  obcd_erase_t erase_st;
  logic [12:0] dly_cnt;
  logic [12:0] dly_len;
  logic [12:0] next_dly_len;
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  sync3;
  logic [1:0]  pin_level;
  logic        in_circuit_programming_mode;
  logic        test_mode;
  logic        bus_req;
  logic        bus_wr;
  logic        erase_cmd;

  // three-stage synchroniser, a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1     <= 2'h0;
      sync2     <= 2'h0;
      sync3     <= 2'h0;
      pin_level <= 2'h0;
    end else begin
      sync1 <= {TEST_MODE_PIN, PROG_MODE_PIN};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 2; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_level[i] <= sync3[i];
        end
      end
    end
  end

  assign in_circuit_programming_mode = pin_level[0];
  assign test_mode                   = pin_level[1];

  // classic wishbone slave, one wait state, ack dropped after one cycle
  assign bus_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign bus_wr    = bus_req && WB_WE_I && WB_SEL_I && in_circuit_programming_mode;
  assign erase_cmd = bus_wr && (WB_ADR_I == `OBCD_ADDR_CMD) && WB_DAT_I[`OBCD_CMD_ERASE];

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 8'h00;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= 8'h00;
      if (bus_req && in_circuit_programming_mode) begin
        unique case (WB_ADR_I)
          `OBCD_ADDR_STORE:  WB_DAT_O <= store;
          `OBCD_ADDR_STATUS: WB_DAT_O <= {4'h0, test_mode, MEM_ERASE_REQ,
                                          erase_st != OBCD_E_IDLE, phase == OBCD_RUN};
          `OBCD_ADDR_ACTIVE: WB_DAT_O <= active;
          default:           WB_DAT_O <= 8'h00;
        endcase
      end
    end
  end

  // non-volatile option store; erase wipes user memory first when protected
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      store    <= `OBCD_ERASED;
      erase_st <= OBCD_E_IDLE;
    end else begin
      unique case (erase_st)
        OBCD_E_IDLE: begin
          if (erase_cmd) begin
            erase_st <= store[`OBCD_BIT_PROTECT] ? OBCD_E_OPT : OBCD_E_MEM;
          end else if (bus_wr && WB_ADR_I == `OBCD_ADDR_STORE) begin
            store <= WB_DAT_I;
          end
        end
        OBCD_E_MEM: begin
          if (MEM_ERASE_DONE) begin
            erase_st <= OBCD_E_OPT;
          end
        end
        OBCD_E_OPT: begin
          store    <= `OBCD_ERASED;
          erase_st <= OBCD_E_IDLE;
        end
        default: erase_st <= OBCD_E_IDLE;
      endcase
    end
  end

  assign MEM_ERASE_REQ = (erase_st == OBCD_E_MEM);

  // loop clock forces the long delay whatever the delay bit says
  always_comb begin
    next_dly_len = `OBCD_DLY_LONG;
    if (store[`OBCD_BIT_RST_DLY] && store[`OBCD_BIT_CLK_SRC]) begin
      next_dly_len = `OBCD_DLY_SHORT;
    end
  end

  // reset phase: latch options, hold cpu for the chosen count, then run
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      phase   <= OBCD_LOAD;
      active  <= `OBCD_ERASED;
      dly_len <= `OBCD_DLY_LONG;
      dly_cnt <= 13'h0000;
    end else begin
      unique case (phase)
        OBCD_LOAD: begin
          active  <= store;
          dly_len <= next_dly_len;
          dly_cnt <= 13'h0001;
          phase   <= OBCD_DELAY;
        end
        OBCD_DELAY: begin
          if (dly_cnt == dly_len) begin
            phase <= OBCD_RUN;
          end else begin
            dly_cnt <= dly_cnt + 13'h0001;
          end
        end
        OBCD_RUN: begin
          if (HALT_EXIT) begin
            dly_cnt <= 13'h0001;
            phase   <= OBCD_DELAY;
          end
        end
        default: phase <= OBCD_LOAD;
      endcase
    end
  end

  assign CPU_RESET_HOLD = (phase != OBCD_RUN);
  assign ACTIVE_OPTIONS = active;

  // static decode of the latched options
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WDG_HW_ENABLE          <= 1'b0;
      CLK_SEL_PLL            <= 1'b0;
      LOW_SUPPLY_DETECTOR_EN <= 1'b0;
      AUX_SUPPLY_DETECTOR_EN <= 1'b0;
      INPUT_CLOCK_HALVER_EN  <= 1'b0;
    end else if (phase == OBCD_LOAD) begin
      WDG_HW_ENABLE          <= !store[`OBCD_BIT_WDG_TYPE];
      CLK_SEL_PLL            <= !store[`OBCD_BIT_CLK_SRC];
      LOW_SUPPLY_DETECTOR_EN <= store[`OBCD_BIT_VD_HI:`OBCD_BIT_VD_LO] != `OBCD_VD_NONE;
      AUX_SUPPLY_DETECTOR_EN <= store[`OBCD_BIT_VD_HI:`OBCD_BIT_VD_LO] == `OBCD_VD_BOTH ||
                                store[`OBCD_BIT_VD_HI:`OBCD_BIT_VD_LO] == `OBCD_VD_ODD;
      INPUT_CLOCK_HALVER_EN  <= !store[`OBCD_BIT_HALVER];
    end
  end

  // halt entry with watchdog running and the latched halt-reset option bit set gives a one-cycle reset request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HALT_WDG_RESET <= 1'b0;
    end else begin
      HALT_WDG_RESET <= HALT_ENTRY && WDG_RUNNING && active[`OBCD_BIT_HALT_RST];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      USER_MEM_ACCESS_BLOCK <= 1'b1;
    end else begin
      USER_MEM_ACCESS_BLOCK <= !active[`OBCD_BIT_PROTECT] &&
                               (in_circuit_programming_mode || test_mode);
    end
  end

  // helper: length of the last hold interval
  logic [12:0] hold_len;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hold_len <= 13'h0000;
    end else if (phase == OBCD_DELAY) begin
      hold_len <= hold_len + 13'h0001;
    end else if (phase == OBCD_RUN && HALT_EXIT) begin
      hold_len <= 13'h0000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_erase_begin;
    erase_cmd && erase_st == OBCD_E_IDLE && !store[`OBCD_BIT_PROTECT];
  endsequence
  sequence s_mem_wiped;
    MEM_ERASE_REQ && MEM_ERASE_DONE;
  endsequence

  a_erase_sets_ones: assert property (
    erase_st == OBCD_E_OPT |=> store == `OBCD_ERASED)
    else $error("erased store not all ones");
  a_hidden_outside_prog: assert property (
    (bus_req && !in_circuit_programming_mode) |=> WB_ACK_O && WB_DAT_O == 8'h00 &&
    $stable(store))
    else $error("option bytes visible outside programming mode");
  a_halt_reset_pulse: assert property (
    (HALT_ENTRY && WDG_RUNNING) |=> HALT_WDG_RESET == $past(active[`OBCD_BIT_HALT_RST]))
    else $error("halt entry reset wrong");
  a_wdg_type_decode: assert property (
    $rose(phase == OBCD_DELAY) && $past(phase) == OBCD_LOAD |->
    WDG_HW_ENABLE == !active[`OBCD_BIT_WDG_TYPE] && CLK_SEL_PLL == !active[`OBCD_BIT_CLK_SRC])
    else $error("watchdog or clock source decode wrong");
  a_detector_decode: assert property (
    phase == OBCD_RUN |-> LOW_SUPPLY_DETECTOR_EN == (active[4:3] != 2'h2) &&
    AUX_SUPPLY_DETECTOR_EN == (active[4:3] != 2'h1 && active[4:3] != 2'h2))
    else $error("detector enables wrong");
  a_hold_length: assert property (
    $fell(CPU_RESET_HOLD) |-> hold_len == (active[2] && active[5] ? 13'h0100 : 13'h1000))
    else $error("reset hold length wrong");
  a_pll_long_delay: assert property (
    (phase == OBCD_LOAD && !store[`OBCD_BIT_CLK_SRC]) |=> dly_len == 13'h1000)
    else $error("loop clock did not force long delay");
  a_halver_decode: assert property (
    phase == OBCD_RUN |-> INPUT_CLOCK_HALVER_EN == !active[`OBCD_BIT_HALVER])
    else $error("halver enable wrong");
  a_protect_blocks: assert property (
    (!active[0] && in_circuit_programming_mode) |=> USER_MEM_ACCESS_BLOCK)
    else $error("protected memory not blocked");
  a_erase_mem_first: assert property (
    s_erase_begin |=> MEM_ERASE_REQ && $stable(store))
    else $error("options erased before memory");
  a_static_options: assert property (
    (phase != OBCD_LOAD && $past(phase) != OBCD_LOAD) |-> $stable(active))
    else $error("latched options changed");

  // the option byte stays untouched for as long as the memory wipe runs
  a_store_kept_wiping: assert property (
    MEM_ERASE_REQ |=> $stable(store))
    else $error("options changed during memory wipe");
  a_wiped_then_ones: assert property (
    s_mem_wiped |=> $stable(store) ##1 store == `OBCD_ERASED)
    else $error("options not erased after memory wipe");

  // bus handshake: one ack per request, dropped in the next cycle
  a_ack_follows_req: assert property (
    bus_req |=> WB_ACK_O)
    else $error("request not acknowledged");
  a_ack_one_cycle: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_prog_write_lands: assert property (
    (bus_wr && WB_ADR_I == `OBCD_ADDR_STORE && erase_st == OBCD_E_IDLE) |=>
    store == $past(WB_DAT_I))
    else $error("programming write lost");
  a_cmd_reads_zero: assert property (
    (bus_req && WB_ADR_I == `OBCD_ADDR_CMD) |=> WB_DAT_O == 8'h00)
    else $error("command register readable");

  // halt entry without a running watchdog never resets
  a_halt_no_reset: assert property (
    !(HALT_ENTRY && WDG_RUNNING) |=> !HALT_WDG_RESET)
    else $error("spurious halt reset");

  // decoded watchdog and clock source follow the latched byte in run phase
  a_wdg_static: assert property (
    phase == OBCD_RUN |-> WDG_HW_ENABLE == !active[`OBCD_BIT_WDG_TYPE])
    else $error("watchdog type output wrong in run");
  a_clk_src_static: assert property (
    phase == OBCD_RUN |-> CLK_SEL_PLL == !active[`OBCD_BIT_CLK_SRC])
    else $error("clock source output wrong in run");

  // delay length and counter stay within the chosen hold
  a_short_delay_pick: assert property (
    (phase == OBCD_LOAD && store[`OBCD_BIT_RST_DLY] && store[`OBCD_BIT_CLK_SRC]) |=>
    dly_len == `OBCD_DLY_SHORT)
    else $error("short delay not chosen");
  a_count_in_range: assert property (
    phase == OBCD_DELAY |-> dly_cnt <= dly_len && hold_len < `OBCD_DLY_LONG)
    else $error("delay counter out of range");
  a_halt_exit_hold: assert property (
    (phase == OBCD_RUN && HALT_EXIT) |=> CPU_RESET_HOLD && dly_cnt == 13'h0001)
    else $error("halt exit did not restart hold");

  // unprotected byte leaves user memory open
  a_protect_open: assert property (
    active[`OBCD_BIT_PROTECT] |=> !USER_MEM_ACCESS_BLOCK)
    else $error("unprotected memory blocked");

  // decoded levels never move once running
  a_outputs_static: assert property (
    (phase == OBCD_RUN && $past(phase) == OBCD_RUN) |->
    $stable({WDG_HW_ENABLE, CLK_SEL_PLL, LOW_SUPPLY_DETECTOR_EN,
             AUX_SUPPLY_DETECTOR_EN, INPUT_CLOCK_HALVER_EN}))
    else $error("decoded options changed while running");
endmodule

// ### hw/obcd_map.svh
// offsets, field positions, reset values and timing counts of the option decoder
`ifndef OBCD_MAP_SVH
`define OBCD_MAP_SVH
`define OBCD_ADDR_STORE    4'h0
`define OBCD_ADDR_CMD      4'h4
`define OBCD_ADDR_STATUS   4'h8
`define OBCD_ADDR_ACTIVE   4'hc
`define OBCD_ERASED        8'hff
`define OBCD_BIT_HALT_RST  7
`define OBCD_BIT_WDG_TYPE  6
`define OBCD_BIT_CLK_SRC   5
`define OBCD_BIT_VD_HI     4
`define OBCD_BIT_VD_LO     3
`define OBCD_BIT_RST_DLY   2
`define OBCD_BIT_HALVER    1
`define OBCD_BIT_PROTECT   0
`define OBCD_CMD_ERASE     0
`define OBCD_VD_BOTH       2'h0
`define OBCD_VD_LOW_ONLY   2'h1
`define OBCD_VD_NONE       2'h2
`define OBCD_VD_ODD        2'h3
`define OBCD_DLY_LONG      13'h1000
`define OBCD_DLY_SHORT     13'h0100
`endif

// ### hw/obcd_pkg.sv
// types shared by the option byte decoder
package obcd_pkg;
  typedef enum logic [1:0] {
    OBCD_LOAD  = 2'b00,
    OBCD_DELAY = 2'b01,
    OBCD_RUN   = 2'b10
  } obcd_phase_t;
  typedef enum logic [1:0] {
    OBCD_E_IDLE = 2'b00,
    OBCD_E_MEM  = 2'b01,
    OBCD_E_OPT  = 2'b10
  } obcd_erase_t;
  typedef logic [7:0] obcd_byte_t;
endpackage

// ### dv/obcd_flash_model.sv
// flash wipe responder that answers the erase request after a delay
module obcd_flash_model #(
  parameter int WIPE_CYCLES = 20
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic erase_req,
  output logic      erase_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      erase_done <= 1'b0;
    end else begin
      // slow wipe: done only after a full count of held request
      erase_done <= erase_req && (cnt == WIPE_CYCLES);
      cnt <= erase_req ? cnt + 1 : 0;
    end
  end
endmodule

// ### dv/testbench.sv
// self-checking bench for the option byte decoder
`include "obcd_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import obcd_pkg::*;
  logic        clk = 0, rst_b = 0, we = 0, sel = 0, cyc = 0, stb = 0;
  logic        prog = 0, test = 0, h_in = 0, h_out = 0, wdg_run = 0;
  logic  [3:0] adr = 0;
  logic  [7:0] wdat = 0, rdat, q;
  logic        ack, e_req, e_done, hold, h_rst, wdg_hw, pll, low_det, aux_det;
  logic        halver, block;
  obcd_byte_t  active;
  logic [31:0] seed;
  int          error_cnt = 0;
  int          checked = 0;

  always #5 clk = ~clk;

  obcd_option_decode i_dut (.CLK(clk), .RST_B(rst_b), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PROG_MODE_PIN(prog), .TEST_MODE_PIN(test), .HALT_ENTRY(h_in),
    .HALT_EXIT(h_out), .WDG_RUNNING(wdg_run), .MEM_ERASE_DONE(e_done),
    .MEM_ERASE_REQ(e_req), .CPU_RESET_HOLD(hold), .HALT_WDG_RESET(h_rst),
    .WDG_HW_ENABLE(wdg_hw), .CLK_SEL_PLL(pll), .LOW_SUPPLY_DETECTOR_EN(low_det),
    .AUX_SUPPLY_DETECTOR_EN(aux_det), .INPUT_CLOCK_HALVER_EN(halver),
    .USER_MEM_ACCESS_BLOCK(block), .ACTIVE_OPTIONS(active));

  obcd_flash_model i_flash (.clk(clk), .rst_b(rst_b), .erase_req(e_req), .erase_done(e_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int hold_len(input logic [7:0] o);
    return (!o[5] || !o[2]) ? 4096 : 256;
  endfunction

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic measure_hold(input int exp);
    int n;
    n = 0;
    while (hold !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= exp - 1 && n <= exp + 2, 1'b1);
  endtask

  task automatic halt(input logic r);
    @(posedge clk);
    h_in <= 1'b1;
    wdg_run <= r;
    @(posedge clk);
    h_in <= 1'b0;
    @(negedge clk);
    chk(h_rst, r);
    @(negedge clk);
    chk(h_rst, 1'b0);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial begin
    seed = 32'h488b;
    repeat (2) @(posedge clk);
    chk({hold, block, active}, {2'b11, `OBCD_ERASED});
    rst_b <= 1'b1;
    measure_hold(hold_len(`OBCD_ERASED) + 1);
    chk({wdg_hw, pll}, 2'b00);
    chk({low_det, aux_det}, 2'b11);
    chk({halver, block}, 2'b00);
    wb(1'b1, `OBCD_ADDR_STORE, 8'h00);
    wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
    chk(q, 8'h00);
    prog <= 1'b1;
    repeat (5) @(posedge clk);
    wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
    chk(q, `OBCD_ERASED);
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 8'h00);
    repeat (6) begin
      seed = lfsr(seed);
      wb(1'b1, `OBCD_ADDR_STORE, seed[7:0]);
      wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
      chk(q, seed[7:0]);
      wb(1'b0, `OBCD_ADDR_ACTIVE, 8'h00);
      chk(q, `OBCD_ERASED);
    end
    // long delay chosen as a resonator-friendly programming
    wb(1'b1, `OBCD_ADDR_STORE, 8'hfb);
    wb(1'b1, `OBCD_ADDR_CMD, 8'h01);
    repeat (3) @(posedge clk);
    chk(e_req, 1'b0);
    wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
    chk(q, `OBCD_ERASED);
    wb(1'b1, `OBCD_ADDR_STORE, 8'hfe);
    wb(1'b1, `OBCD_ADDR_CMD, 8'h01);
    wb(1'b0, `OBCD_ADDR_STATUS, 8'h00);
    chk(q, 8'h07);
    wb(1'b1, `OBCD_ADDR_STORE, 8'h12);
    wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
    chk(q, 8'hfe);
    while (e_req !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    wb(1'b0, `OBCD_ADDR_STORE, 8'h00);
    chk(q, `OBCD_ERASED);
    test <= 1'b1;
    repeat (5) @(posedge clk);
    wb(1'b0, `OBCD_ADDR_STATUS, 8'h00);
    chk(q, 8'h09);
    chk(block, 1'b0);
    halt(1'b1);
    halt(1'b0);
    @(posedge clk);
    h_out <= 1'b1;
    @(posedge clk);
    h_out <= 1'b0;
    @(negedge clk);
    chk(hold, 1'b1);
    measure_hold(256);
    conclude();
  end
endmodule
